// ==== aak_defines.vh ====
`ifndef AAK_DEFINES_VH
`define AAK_DEFINES_VH
`define AAK_SERVO_ACC_MIN   24'h00_0001
`define AAK_SERVO_ACC_MAX   24'hFF_FFFF
`define AAK_SERVO_ACC_RST   24'h08_0000
`define AAK_STEP_ACC_MIN    24'h00_0001
`define AAK_STEP_ACC_MAX    24'h4F_FFFF
`define AAK_STEP_ACC_RST    24'h00_0003
`define AAK_FACT_MIN        4'h1
`define AAK_FACT_MAX        4'hA
`define AAK_FACT_RST        4'h1
`define AAK_ACC_W           24
`define AAK_FACT_W          4
`endif

// ==== aak_boost.v ====
`timescale 1ns/1ns
`include "aak_defines.vh"
// effective stepper acceleration: factor at standstill, tapering linearly to 1x at target rate
module aak_boost #(
  parameter VEL_W = 24
) (
  // clock and reset
  input  wire                     clk,
  input  wire                     rst_n,
  // operands
  input  wire [`AAK_ACC_W-1:0]    accel,
  input  wire [`AAK_FACT_W-1:0]   factor,
  input  wire [VEL_W-1:0]         velAbs,
  input  wire [VEL_W-1:0]         velTarget,
  // result
  output reg  [`AAK_ACC_W+3:0]    effAccel
);
  // scaled = 1 + (f-1)*(1 - v/vt), computed in 1/16 steps to keep the divider small
  reg  [4:0]            frac16;
  wire [VEL_W+3:0]      num = {velAbs, 4'h0};
  wire [VEL_W+3:0]      quot = (velTarget == {VEL_W{1'b0}}) ? {(VEL_W+4){1'b0}}
                                 : num / {4'h0, velTarget};
  wire [8:0]            mult;
  wire [`AAK_ACC_W+12:0] prod;
  always @* begin
    if (quot >= {{VEL_W{1'b0}}, 4'hF} + 1'b1)
      frac16 = 5'h00;
    else
      frac16 = 5'h10 - {1'b0, quot[3:0]};
  end
  assign mult = 9'h010 + ({5'h00, factor - 4'h1} * {4'h0, frac16});
  assign prod = {4'h0, accel} * {4'h0, mult};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      effAccel <= {(`AAK_ACC_W+4){1'b0}};
    else
      effAccel <= prod[`AAK_ACC_W+7:4];
  end
endmodule

// ==== aak_axis_ctrl.v ====
`timescale 1ns/1ns
`include "aak_defines.vh"
module aak_axis_ctrl #(
  parameter VEL_W = 24,
  parameter POS_W = 32
) (
  // clock and reset
  input  wire                     clk_sys,
  input  wire                     nrst,
  // configuration
  input  wire                     stepperMode,
  input  wire                     accWr,
  input  wire [31:0]              accWrData,
  input  wire                     factWr,
  input  wire [15:0]              factWrData,
  // motion commands
  input  wire                     motionStart,
  input  wire                     haltCmd,
  input  wire                     trajRunning,
  input  wire [VEL_W-1:0]         velAbs,
  input  wire [VEL_W-1:0]         velTarget,
  input  wire                     trigBufPending,
  input  wire                     trigBufReleased,
  input  wire                     stepPulseIn,
  input  wire                     dirPulseIn,
  // in-position check
  input  wire                     inPosReq,
  input  wire signed [POS_W-1:0]  presentPos,
  input  wire signed [POS_W-1:0]  targetPos,
  input  wire [POS_W-1:0]         deadband,
  // outputs
  output reg  [`AAK_ACC_W-1:0]    accelQ,
  output reg  [`AAK_FACT_W-1:0]   factorQ,
  output reg  [`AAK_ACC_W+3:0]    rampAccel,
  output reg  [`AAK_ACC_W+3:0]    rampDecel,
  output reg                      motorEnable,
  output reg                      inhibitOut,
  output reg                      trigBufPurge,
  output reg                      stepOut,
  output reg                      dirOut,
  output reg                      killed,
  output reg  [POS_W-1:0]         inPosResult,
  output reg                      inPosValid
);
  reg rstMeta_q;
  reg rstSync_q;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire rst_n = rstSync_q;

  // saturate a 32-bit write into [lo, hi]
  function [`AAK_ACC_W-1:0] clampAcc;
    input [31:0]            val;
    input [`AAK_ACC_W-1:0]  lo;
    input [`AAK_ACC_W-1:0]  hi;
    begin
      if (val < {8'h00, lo})
        clampAcc = lo;
      else if (val > {8'h00, hi})
        clampAcc = hi;
      else
        clampAcc = val[`AAK_ACC_W-1:0];
    end
  endfunction

  wire [`AAK_ACC_W-1:0] accLo = stepperMode ? `AAK_STEP_ACC_MIN : `AAK_SERVO_ACC_MIN;
  wire [`AAK_ACC_W-1:0] accHi = stepperMode ? `AAK_STEP_ACC_MAX : `AAK_SERVO_ACC_MAX;
  wire [`AAK_ACC_W-1:0] accRst;
  assign accRst = stepperMode ? `AAK_STEP_ACC_RST : `AAK_SERVO_ACC_RST;

  // power-up default depends on the mode strap, so catch it once after release
  reg defLoaded_q;
  reg [`AAK_FACT_W-1:0] factClamp;
  always @* begin
    if (factWrData < {12'h000, `AAK_FACT_MIN})
      factClamp = `AAK_FACT_MIN;
    else if (factWrData > {12'h000, `AAK_FACT_MAX})
      factClamp = `AAK_FACT_MAX;
    else
      factClamp = factWrData[`AAK_FACT_W-1:0];
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      accelQ      <= `AAK_SERVO_ACC_RST;
      factorQ     <= `AAK_FACT_RST;
      defLoaded_q <= 1'b0;
    end else begin
      defLoaded_q <= 1'b1;
      if (!defLoaded_q)
        accelQ <= accRst;
      else if (accWr && !trajRunning)
        accelQ <= clampAcc(accWrData, accLo, accHi);
      if (factWr)
        factorQ <= factClamp;
    end
  end

  wire [`AAK_ACC_W+3:0] boosted;
  aak_boost #(
    .VEL_W (VEL_W)
  ) uBoost (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .accel     (accelQ),
    .factor    (factorQ),
    .velAbs    (velAbs),
    .velTarget (velTarget),
    .effAccel  (boosted)
  );

  // same value for both ramp directions
  wire [`AAK_ACC_W+3:0] rampNext = stepperMode ? boosted : {4'h0, accelQ};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rampAccel <= {(`AAK_ACC_W+4){1'b0}};
      rampDecel <= {(`AAK_ACC_W+4){1'b0}};
    end else begin
      rampAccel <= rampNext;
      rampDecel <= rampNext;
    end
  end

  // kill state: halt wins over a start in the same cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      killed       <= 1'b0;
      motorEnable  <= 1'b0;
      inhibitOut   <= 1'b0;
      trigBufPurge <= 1'b0;
    end else begin
      trigBufPurge <= haltCmd && (trigBufPending || trigBufReleased || 1'b1);
      if (haltCmd) begin
        killed      <= 1'b1;
        motorEnable <= 1'b0;
        inhibitOut  <= 1'b1;
      end else if (motionStart) begin
        killed      <= 1'b0;
        motorEnable <= 1'b1;
        inhibitOut  <= 1'b0;
      end
    end
  end

  // gated by the halt command directly so no pulse escapes in the halt cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stepOut <= 1'b0;
      dirOut  <= 1'b0;
    end else if (haltCmd || (killed && !motionStart)) begin
      stepOut <= 1'b0;
      dirOut  <= 1'b0;
    end else begin
      stepOut <= stepperMode & stepPulseIn;
      dirOut  <= stepperMode & dirPulseIn;
    end
  end

  // in-position compare, one cycle latency
  wire signed [POS_W:0] diff = {presentPos[POS_W-1], presentPos}
                             - {targetPos[POS_W-1], targetPos};
  wire [POS_W:0] absDiff = diff[POS_W] ? -diff : diff;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inPosResult <= {POS_W{1'b0}};
      inPosValid  <= 1'b0;
    end else begin
      inPosValid <= inPosReq;
      if (inPosReq) begin
        if (absDiff <= {1'b0, deadband})
          inPosResult <= {POS_W{1'b0}};
        else
          inPosResult <= absDiff[POS_W-1:0];
      end
    end
  end
endmodule

// ==== aak_drv_model.sv ====
`timescale 1ns/1ns
// amplifier only powers the motor when enabled and not inhibited
module aak_drv_model (
  // from axis
  input  wire logic motorEnable,
  input  wire logic inhibitOut,
  // status
  output logic      driverOn
);
  assign driverOn = motorEnable & ~inhibitOut;
endmodule

// ==== aak_axis_chk.sv ====
`timescale 1ns/1ns
module aak_axis_chk #(
  parameter POS_W = 32
) (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    nrst,
  // design inputs
  input wire logic                    stepperMode,
  input wire logic                    accWr,
  input wire logic                    trajRunning,
  input wire logic                    haltCmd,
  input wire logic                    motionStart,
  input wire logic                    inPosReq,
  input wire logic signed [POS_W-1:0] presentPos,
  input wire logic signed [POS_W-1:0] targetPos,
  // design outputs
  input wire logic [23:0]             accelQ,
  input wire logic [3:0]              factorQ,
  input wire logic [27:0]             rampAccel,
  input wire logic [27:0]             rampDecel,
  input wire logic                    motorEnable,
  input wire logic                    inhibitOut,
  input wire logic                    trigBufPurge,
  input wire logic                    stepOut,
  input wire logic                    dirOut,
  input wire logic                    killed,
  input wire logic                    inPosValid,
  input wire logic [POS_W-1:0]        inPosResult
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_halt; haltCmd; endsequence
  sequence s_servo_wr; accWr && !trajRunning && !stepperMode ##1 !accWr [*2]; endsequence
  a_halt_motor_off: assert property (s_halt |=> !motorEnable && killed)
    else $error("motor enabled after halt");
  a_halt_inhibit: assert property (s_halt |=> inhibitOut)
    else $error("inhibit not driven after halt");
  a_halt_purge: assert property (s_halt |=> trigBufPurge)
    else $error("no purge after halt");
  a_kill_no_step: assert property (killed |-> !stepOut && !dirOut)
    else $error("step output while halted");
  a_acc_nonzero: assert property (accelQ != 24'h00_0000)
    else $error("acceleration zero");
  a_fact_range: assert property (factorQ >= 4'h1 && factorQ <= 4'hA)
    else $error("factor out of range");
  a_acc_frozen: assert property (accWr && trajRunning |=> $stable(accelQ))
    else $error("acceleration changed while moving");
  a_servo_ramp: assert property (s_servo_wr |->
    rampAccel == {4'h0, accelQ} && rampDecel == rampAccel)
    else $error("ramp differs from stored acceleration");
  a_kill_holds: assert property (killed && !motionStart |=> killed)
    else $error("halt released without start");
  a_inpos_zero: assert property (inPosReq && presentPos == targetPos |=>
    inPosValid && inPosResult == 0)
    else $error("in-position result not zero");
endmodule
bind aak_axis_ctrl aak_axis_chk #(
  .POS_W (POS_W)
) u_chk (
  .clk_sys      (clk_sys),
  .nrst         (nrst),
  .stepperMode  (stepperMode),
  .accWr        (accWr),
  .trajRunning  (trajRunning),
  .haltCmd      (haltCmd),
  .motionStart  (motionStart),
  .inPosReq     (inPosReq),
  .presentPos   (presentPos),
  .targetPos    (targetPos),
  .accelQ       (accelQ),
  .factorQ      (factorQ),
  .rampAccel    (rampAccel),
  .rampDecel    (rampDecel),
  .motorEnable  (motorEnable),
  .inhibitOut   (inhibitOut),
  .trigBufPurge (trigBufPurge),
  .stepOut      (stepOut),
  .dirOut       (dirOut),
  .killed       (killed),
  .inPosValid   (inPosValid),
  .inPosResult  (inPosResult)
);

// ==== aak_axis_ctrl_tb.sv ====
`timescale 1ns/1ns
module aak_axis_ctrl_tb;
  logic clk_sys = 0, nrst = 0, stepperMode = 0, accWr = 0, factWr = 0, motionStart = 0;
  logic haltCmd = 0, trajRunning = 0, inPosReq = 0, stepPulseIn = 0, dirPulseIn = 0;
  logic [31:0] accWrData = 0, deadband = 0, inPosResult;
  logic signed [31:0] presentPos = 0, targetPos = 0;
  logic [15:0] factWrData = 0;
  logic [23:0] velAbs = 0, velTarget = 0, accelQ;
  logic [3:0]  factorQ;
  logic [27:0] rampAccel, rampDecel;
  logic motorEnable, inhibitOut, trigBufPurge, stepOut, dirOut, killed, inPosValid, driverOn;
  int n_mismatch = 0, checks_done = 0;
  always #5 clk_sys = ~clk_sys;
  // pending/released flags are informative only, so tied off
  aak_axis_ctrl uut (.*, .trigBufPending(1'b0), .trigBufReleased(1'b0));
  aak_drv_model drv (.*);
  task cyc(input int n); repeat (n) @(posedge clk_sys); #1; endtask
  task chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task reset(input logic mode); nrst = 0; stepperMode = mode; cyc(2); nrst = 1; cyc(4); endtask
  // two idle edges after a write so back-to-back calls never re-raise the strobe at once
  task acc(input [31:0] d);
    accWr = 1;
    accWrData = d;
    cyc(1);
    accWr = 0;
    cyc(2);
  endtask
  task fact(input [15:0] d);
    factWr = 1;
    factWrData = d;
    cyc(1);
    factWr = 0;
    cyc(1);
  endtask
  task inpos(input [31:0] p, t, d, e);
    presentPos = p;
    targetPos = t;
    deadband = d;
    inPosReq = 1;
    cyc(1);
    inPosReq = 0;
    chk(inPosValid, 1);
    chk(inPosResult, e);
    cyc(1);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000; n_mismatch++; test_done;
  end
  initial begin
    reset(0);
    chk(accelQ, 24'h08_0000);
    chk(factorQ, 4'h1);
    acc(0);
    chk(rampAccel, 1);
    chk(rampDecel, 1);
    acc(32'h0100_0000);
    chk(accelQ, 24'hFF_FFFF);
    trajRunning = 1;
    acc(5);
    chk(accelQ, 24'hFF_FFFF);
    trajRunning = 0;
    fact(0);
    chk(factorQ, 4'h1);
    fact(16'h00FF);
    chk(factorQ, 4'hA);
    motionStart = 1;
    cyc(1);
    motionStart = 0;
    chk(driverOn, 1);
    haltCmd = 1;
    stepPulseIn = 1;
    cyc(1);
    haltCmd = 0;
    chk(motorEnable, 0);
    chk(inhibitOut, 1);
    chk(trigBufPurge, 1);
    chk(stepOut, 0);
    cyc(1);
    chk(trigBufPurge, 0);
    cyc(3);
    chk(driverOn, 0);
    stepPulseIn = 0;
    inpos(10, 4, 5, 6);
    inpos(10, 4, 6, 0);
    inpos(-3, -3, 0, 0);
    inpos(-8, 4, 2, 12);
    reset(1);
    chk(accelQ, 3);
    acc(32'hFFFF_FFFF);
    chk(accelQ, 24'h4F_FFFF);
    fact(4);
    velTarget = 100;
    cyc(3);
    chk(rampAccel, 28'h13F_FFFC);
    velAbs = 100;
    cyc(3);
    chk(rampAccel, 28'h04F_FFFF);
    // stepper pulses must pass while running, so the halt check below can fail
    motionStart = 1;
    stepPulseIn = 1;
    dirPulseIn = 1;
    cyc(1);
    motionStart = 0;
    chk(stepOut, 1);
    chk(dirOut, 1);
    haltCmd = 1;
    cyc(1);
    haltCmd = 0;
    chk(stepOut, 0);
    chk(dirOut, 0);
    chk(killed, 1);
    cyc(2);
    chk(stepOut, 0);
    chk(motorEnable, 0);
    stepPulseIn = 0;
    dirPulseIn = 0;
    test_done;
  end
endmodule
